/* core/vsp_pkg.sv */
// Constants, register map and types for the video stream packet sink.
// Assumes one clock domain and AHB-Lite register access with 32-bit words.
package vsp_pkg;
  // Link shape: symbol width per sample and symbols per beat, fixed.
  localparam int SYM_W = 8;
  localparam int SYM_N = 3;
  localparam int DATA_W = SYM_W * SYM_N;
  localparam int NIB_W = 4;
  localparam int DIM_W = 16;
  localparam int CTRL_NIBS = 9;
  localparam logic [1:0] CTRL_BEATS = 2'd3;
  localparam int ACC_W = CTRL_NIBS * NIB_W;

  // Packet type codes.
  localparam logic [3:0] TYPE_VIDEO = 4'h0;
  localparam logic [3:0] TYPE_USER_LO = 4'h1;
  localparam logic [3:0] TYPE_USER_HI = 4'h8;
  localparam logic [3:0] TYPE_ANC = 4'hd;
  localparam logic [3:0] TYPE_CTRL = 4'hf;

  // Upper interlacing pair.
  localparam logic [1:0] ILACE_PROG = 2'b00;
  localparam logic [1:0] ILACE_EVEN = 2'b10;
  localparam logic [1:0] ILACE_ODD = 2'b11;
  // Lower pair: field pairing unknown, progressive source unknown.
  localparam logic [1:0] PAIR_UNKNOWN = 2'b11;
  localparam logic [1:0] LAST_UNKNOWN = 2'b10;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WIDTH = 8'h08;
  localparam logic [7:0] REG_HEIGHT = 8'h0c;
  localparam logic [7:0] REG_ILACE = 8'h10;
  localparam logic [7:0] REG_FRAMES = 8'h14;

  // Field positions and reset values.
  localparam int CTRL_EN_BIT = 0;
  localparam int ERR_N = 4;
  localparam int ERR_LSB = 8;
  localparam int ERR_SIZE = 0;
  localparam int ERR_NOCTRL = 1;
  localparam int ERR_SHORT = 2;
  localparam int ERR_RSVD = 3;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [15:0] DIM_RST = 16'h0000;
  localparam logic [3:0] ILACE_RST = 4'h3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CTRL  = 4'b0010,
    ST_VIDEO = 4'b0100,
    ST_OTHER = 4'b1000
  } vsp_state_type;
endpackage : vsp_pkg

/* core/vsp_ctrl_nibbles.sv */
// Collects the nibbles of a control packet payload into width, height, interlacing.
// Assumes take is high only for accepted payload beats of a control packet.
`timescale 1ns/1ps
module vsp_ctrl_nibbles
  import vsp_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Payload beats
  input wire logic clear,
  input wire logic take,
  input wire logic [DATA_W-1:0] sym,
  // Decoded payload
  output logic done,
  output logic [DIM_W-1:0] width,
  output logic [DIM_W-1:0] height,
  output logic [NIB_W-1:0] ilace
);
  logic [1:0] cnt_ff;
  logic [ACC_W-1:0] acc_ff;
  logic done_ff;
  logic [SYM_N*NIB_W-1:0] beat_nibs;
  wire room = (cnt_ff != CTRL_BEATS);

  // The least significant symbol carries the earlier nibble; upper symbol bits are ignored.
  genvar g;
  generate
    for (g = 0; g < SYM_N; g++) begin : g_nib
      assign beat_nibs[(SYM_N-g)*NIB_W-1 -: NIB_W] = sym[g*SYM_W +: NIB_W];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 2'd0;
      acc_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= take && room && (cnt_ff == CTRL_BEATS - 2'd1);
      if (clear) begin
        cnt_ff <= 2'd0;
      end else if (take && room) begin
        cnt_ff <= cnt_ff + 2'd1;
        acc_ff <= {acc_ff[ACC_W-SYM_N*NIB_W-1:0], beat_nibs};
      end
    end
  end

  assign done = done_ff;
  assign width = acc_ff[ACC_W-1 -: DIM_W];
  assign height = acc_ff[ACC_W-DIM_W-1 -: DIM_W];
  assign ilace = acc_ff[NIB_W-1:0];
endmodule : vsp_ctrl_nibbles

/* core/vsp_sink.sv */
// Video stream packet sink: parses packets, tracks raster position, AHB-Lite registers.
// Assumes a single clock, a backpressured stream source, and a single-transfer AHB-Lite master.
// What this block does
// - Decode type: video, user, reserved, ancillary, control.
// - Type fifteen configures following video packets.
// - Control payload: width, height, interlacing nibble.
// - One video packet holds one frame or field.
// - Pixels arrive in raster order.
// - Sample width sets symbol width for all packets.
// - Symbols are at least four bits wide.
// - Colour pattern fixed within a video packet.
// - Columns in time; top sample in MSB symbol.
// - Samples per cycle fix symbols per beat.
// - Multi-pixel patterns share a colour plane.
// - Subsampled position: upper plane on even rows.
// - Width is pixels per line; height lines.
// - Upper interlacing bits: progressive, even, odd field.
// - Even field holds even lines, odd holds odd.
// - Field packets: lower bits give pairing.
// - Type code first, in least significant symbol.
// - Control nibbles in order, low symbol first.
// - Field pairing: even, odd, unknown.
// - Progressive: last field, unknown, not deinterlaced.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module vsp_sink
  import vsp_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Stream sink
  input wire logic [DATA_W-1:0] st_data,
  input wire logic st_valid,
  input wire logic st_sop,
  input wire logic st_eop,
  output logic st_ready,
  // Pixel output
  output logic pix_valid,
  output logic [DATA_W-1:0] pix_data,
  output logic [DIM_W-1:0] pix_x,
  output logic [DIM_W-1:0] pix_line,
  output logic pix_lower_plane
);
  vsp_state_type state_ff, nxt_state;
  logic en_ff;
  logic [3:0] last_type_ff;
  logic fresh_ff;
  logic [DIM_W-1:0] act_w_ff, act_h_ff, x_ff, y_ff;
  logic [NIB_W-1:0] act_il_ff;
  logic [31:0] frames_ff;
  logic [ERR_N-1:0] err_ff, err_set, err_clr;
  logic pix_valid_ff, pix_lower_ff;
  logic [DATA_W-1:0] pix_data_ff;
  logic [DIM_W-1:0] pix_x_ff, pix_line_ff;
  logic dp_we_ff;
  logic [7:0] dp_addr_ff;
  logic [31:0] hrdata_ff;
  logic ctrl_done;
  logic [DIM_W-1:0] cfg_w, cfg_h;
  logic [NIB_W-1:0] cfg_il;

  // Stream decode. The packet type sits in the low nibble of the first beat.
  wire beat = st_valid && st_ready;
  wire sop_beat = beat && st_sop;
  wire [3:0] pkt_type = st_data[3:0];
  wire is_video = (pkt_type == TYPE_VIDEO);
  wire is_ctrl = (pkt_type == TYPE_CTRL);
  wire is_user = (pkt_type >= TYPE_USER_LO) && (pkt_type <= TYPE_USER_HI);
  wire is_anc = (pkt_type == TYPE_ANC);
  wire is_rsvd = !is_video && !is_ctrl && !is_user && !is_anc;
  wire body_beat = beat && !st_sop;
  wire vid_beat = body_beat && (state_ff == ST_VIDEO);
  wire ctrl_beat = body_beat && (state_ff == ST_CTRL);
  wire last_col = (x_ff == act_w_ff - 16'd1);
  wire last_row = (y_ff == act_h_ff - 16'd1);
  wire last_pix = last_col && last_row;
  wire il_field = act_il_ff[3];
  wire il_odd = act_il_ff[2];
  wire [DIM_W-1:0] img_row = il_field ? {y_ff[DIM_W-2:0], il_odd} : y_ff;

  // A video packet without a fresh control packet keeps the old size and, for field content, alternates the field.
  wire vid_start = sop_beat && is_video && !st_eop;
  wire keep_cfg = vid_start && !fresh_ff;
  wire ctrl_pend = (state_ff == ST_CTRL);

  // Packet state: a start of packet always resynchronises, whatever the state.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE, ST_CTRL, ST_VIDEO, ST_OTHER: begin
        if (sop_beat && !st_eop) begin
          if (is_ctrl) begin
            nxt_state = ST_CTRL;
          end else if (is_video) begin
            nxt_state = ST_VIDEO;
          end else begin
            nxt_state = ST_OTHER;
          end
        end else if (beat && st_eop) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // The third payload beat completes the nine nibbles; an end on an earlier payload beat is short.
  logic [1:0] ctrl_beats_ff;
  wire ctrl_done_soon = (ctrl_beats_ff >= CTRL_BEATS - 2'd1);

  // Sticky error events.
  assign err_set[ERR_SIZE] = (vid_beat && (st_eop != last_pix)) || (sop_beat && is_video && st_eop);
  assign err_set[ERR_NOCTRL] = keep_cfg;
  assign err_set[ERR_SHORT] = ctrl_pend && beat && st_eop && !st_sop && !ctrl_done_soon;
  assign err_set[ERR_RSVD] = sop_beat && is_rsvd;

  vsp_ctrl_nibbles u_nibbles (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(sop_beat),
    .take(ctrl_beat),
    .sym(st_data),
    .done(ctrl_done),
    .width(cfg_w),
    .height(cfg_h),
    .ilace(cfg_il)
  );

  // Register bus decode. Zero wait states: hrdata is loaded at the address phase.
  wire a_sel = hsel && htrans[1] && hready;
  wire a_rd = a_sel && !hwrite;
  wire [7:0] a_off = haddr[7:0];
  wire wr_ctrl = dp_we_ff && (dp_addr_ff == REG_CTRL);
  wire wr_status = dp_we_ff && (dp_addr_ff == REG_STATUS);
  assign err_clr = wr_status ? hwdata[ERR_LSB +: ERR_N] : '0;
  wire [1:0] pair_code = act_il_ff[1:0];
  wire pair_known = il_field ? (pair_code != PAIR_UNKNOWN) : (pair_code != LAST_UNKNOWN);
  wire [31:0] rd_status = {20'h00000, err_ff, 2'b00, (state_ff != ST_IDLE), fresh_ff, last_type_ff};
  wire [31:0] rd_ilace = {23'h000000, pair_known, pair_code, il_odd, il_field, act_il_ff};
  wire [31:0] rd_mux =
    (a_off == REG_CTRL) ? {31'h00000000, en_ff} :
    (a_off == REG_STATUS) ? rd_status :
    (a_off == REG_WIDTH) ? {16'h0000, act_w_ff} :
    (a_off == REG_HEIGHT) ? {16'h0000, act_h_ff} :
    (a_off == REG_ILACE) ? rd_ilace :
    (a_off == REG_FRAMES) ? frames_ff : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_we_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
      en_ff <= CTRL_EN_RST;
    end else begin
      dp_we_ff <= a_sel && hwrite;
      dp_addr_ff <= a_off;
      if (a_rd) begin
        hrdata_ff <= rd_mux;
      end
      if (wr_ctrl) begin
        en_ff <= hwdata[CTRL_EN_BIT];
      end
    end
  end

  // A hardware event in the same cycle as a clear keeps the bit set.
  genvar e;
  generate
    for (e = 0; e < ERR_N; e++) begin : g_err
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          err_ff[e] <= 1'b0;
        end else begin
          err_ff[e] <= err_set[e] || (err_ff[e] && !err_clr[e]);
        end
      end
    end
  endgenerate

  // Packet state and active configuration.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      last_type_ff <= TYPE_VIDEO;
      fresh_ff <= 1'b0;
      ctrl_beats_ff <= 2'd0;
      act_w_ff <= DIM_RST;
      act_h_ff <= DIM_RST;
      act_il_ff <= ILACE_RST;
      frames_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      if (sop_beat) begin
        last_type_ff <= pkt_type;
        ctrl_beats_ff <= 2'd0;
      end else if (ctrl_beat && !ctrl_done_soon) begin
        ctrl_beats_ff <= ctrl_beats_ff + 2'd1;
      end
      // The latest complete control packet wins.
      if (ctrl_done) begin
        act_w_ff <= cfg_w;
        act_h_ff <= cfg_h;
        act_il_ff <= cfg_il;
        fresh_ff <= 1'b1;
      end else if (vid_start) begin
        fresh_ff <= 1'b0;
        if (keep_cfg && il_field) begin
          act_il_ff[2] <= !il_odd;
        end
      end
      if (vid_beat && st_eop) begin
        frames_ff <= frames_ff + 32'd1;
      end
    end
  end

  // Raster position: rightward along a line, then the leftmost pixel of the next line.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      x_ff <= 16'h0000;
      y_ff <= 16'h0000;
    end else if (vid_start) begin
      x_ff <= 16'h0000;
      y_ff <= 16'h0000;
    end else if (vid_beat) begin
      if (last_col) begin
        x_ff <= 16'h0000;
        y_ff <= y_ff + 16'd1;
      end else begin
        x_ff <= x_ff + 16'd1;
      end
    end
  end

  // Pixel output. The bus is passed whole, so the top pattern row stays in the top symbol.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix_valid_ff <= 1'b0;
      pix_data_ff <= '0;
      pix_x_ff <= 16'h0000;
      pix_line_ff <= 16'h0000;
      pix_lower_ff <= 1'b0;
    end else begin
      pix_valid_ff <= vid_beat;
      if (vid_beat) begin
        pix_data_ff <= st_data;
        pix_x_ff <= x_ff;
        pix_line_ff <= img_row;
        pix_lower_ff <= img_row[0];
      end
    end
  end

  // Outputs.
  assign st_ready = en_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign pix_valid = pix_valid_ff;
  assign pix_data = pix_data_ff;
  assign pix_x = pix_x_ff;
  assign pix_line = pix_line_ff;
  assign pix_lower_plane = pix_lower_ff;

  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_vid_beat;
    vid_beat;
  endsequence
  sequence s_wrap;
    vid_beat && last_col && !st_eop;
  endsequence

  chk_sym_width: assert property (SYM_W >= 4)
    else $error("symbol width below four bits");
  chk_type_ctrl: assert property (sop_beat && is_ctrl && !st_eop |=> state_ff == ST_CTRL)
    else $error("control type did not enter control state");
  chk_type_first: assert property (sop_beat |=> last_type_ff == $past(st_data[3:0]))
    else $error("type not taken from low nibble");
  chk_ctrl_load: assert property (ctrl_done |=> act_w_ff == $past(cfg_w) && act_h_ff == $past(cfg_h))
    else $error("control values not loaded");
  chk_raster_wrap: assert property (s_wrap |=> x_ff == 16'h0000 && y_ff == $past(y_ff) + 16'd1)
    else $error("raster did not wrap to next line");
  chk_msb_symbol: assert property (s_vid_beat |=> pix_valid &&
    pix_data[DATA_W-1 -: SYM_W] == $past(st_data[DATA_W-1 -: SYM_W]))
    else $error("top symbol not carried in order");
  chk_field_line: assert property (vid_beat && il_field |=> pix_line[0] == $past(il_odd))
    else $error("field line parity wrong");
  chk_size_error: assert property (vid_beat && st_eop && !last_pix |=> err_ff[ERR_SIZE] [*2])
    else $error("size error not held");
  chk_set_wins: assert property (err_set[ERR_RSVD] && err_clr[ERR_RSVD] |=> err_ff[ERR_RSVD])
    else $error("event lost against clear");
  chk_ready_beat: assert property (st_valid && !en_ff |-> !beat ##1 !pix_valid)
    else $error("beat taken while disabled");

  // Each sticky flag must show its event one edge later, whatever a clear in the same cycle asks.
  sequence s_short_end;
    ctrl_pend && beat && st_eop && !st_sop && !ctrl_done_soon;
  endsequence
  sequence s_size_clr;
    wr_status && hwdata[ERR_LSB+ERR_SIZE] && !err_set[ERR_SIZE];
  endsequence
  chk_noctrl_flag: assert property (vid_start && !fresh_ff |=> err_ff[ERR_NOCTRL])
    else $error("video without control not flagged");
  chk_short_ctrl: assert property (s_short_end |=> err_ff[ERR_SHORT])
    else $error("short control packet not flagged");
  chk_rsvd_flag: assert property (sop_beat && is_rsvd |=> err_ff[ERR_RSVD])
    else $error("reserved type not flagged");
  chk_status_clear: assert property (s_size_clr |=> !err_ff[ERR_SIZE])
    else $error("size flag not cleared by write");

  // Raster and frame counters, pixel outputs, the active configuration and the enable bit.
  sequence s_vid_start;
    vid_start;
  endsequence
  sequence s_step;
    vid_beat && !last_col;
  endsequence
  chk_vid_start: assert property (s_vid_start |=> x_ff == 16'h0000 && y_ff == 16'h0000)
    else $error("raster not restarted at video start");
  chk_raster_step: assert property (s_step |=> x_ff == $past(x_ff) + 16'd1 && y_ff == $past(y_ff))
    else $error("raster did not step right");
  chk_lower_plane: assert property (s_vid_beat |=> pix_lower_plane == pix_line[0])
    else $error("lower plane flag differs from row parity");
  chk_pix_hold: assert property (!vid_beat |=> !pix_valid && $stable(pix_data))
    else $error("pixel output moved without a beat");
  chk_frame_count: assert property (vid_beat && st_eop |=> frames_ff == $past(frames_ff) + 32'd1)
    else $error("frame count not advanced");
  chk_ilace_load: assert property (ctrl_done |=> act_il_ff == $past(cfg_il))
    else $error("interlacing nibble not loaded");
  chk_field_toggle: assert property (keep_cfg && il_field && !ctrl_done |=> act_il_ff[2] != $past(il_odd))
    else $error("field type not toggled");
  chk_en_write: assert property (wr_ctrl |=> en_ff == $past(hwdata[CTRL_EN_BIT]))
    else $error("enable write not taken");
endmodule : vsp_sink

/* tb/vsp_src_model.sv */
// Upstream stream source model that feeds packets into the sink.
// Assumes callers enter its tasks just after a rising edge of hclk.
`timescale 1ns/1ps
module vsp_src_model
  import vsp_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Stream
  input wire logic st_ready,
  output logic [DATA_W-1:0] st_data,
  output logic st_valid,
  output logic st_sop,
  output logic st_eop
);
  initial begin
    st_data = '0;
    st_valid = 1'b0;
    st_sop = 1'b0;
    st_eop = 1'b0;
  end

  // Idle data is inverted so a sink that ignores valid sees a changed value.
  task automatic idle(input int n);
    st_valid <= 1'b0;
    st_sop <= 1'b0;
    st_eop <= 1'b0;
    st_data <= ~st_data;
    repeat (n) @(posedge hclk);
  endtask : idle

  // Valid is held up between beats sent with no gap, so back-to-back beats never drive it twice in one step.
  task automatic send(input logic [DATA_W-1:0] d, input logic s, input logic e, input int gap);
    if (gap > 0) idle(gap);
    st_data <= d;
    st_sop <= s;
    st_eop <= e;
    st_valid <= 1'b1;
    @(posedge hclk);
    while (st_ready !== 1'b1) @(posedge hclk);
  endtask : send
endmodule : vsp_src_model

/* tb/tb_vsp_sink.sv */
// Self-checking bench for the video stream packet sink.
// Assumes a zero-wait AHB-Lite slave and one upstream source model.
`timescale 1ns/1ps
module tb_vsp_sink;
  import vsp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, junk;
  logic hreadyout, hresp, st_valid, st_sop, st_eop, st_ready, pix_valid, pix_lower_plane;
  logic [DATA_W-1:0] st_data, pix_data;
  logic [DIM_W-1:0] pix_x, pix_line;
  logic [56:0] pq[$];
  logic [3:0] ilace_list [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
  logic [3:0] type_list [6] = '{4'h1, 4'h8, 4'h9, 4'hd, 4'he, 4'hc};
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int frames = 0;

  always #2.5 hclk = ~hclk;

  vsp_sink i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .st_data(st_data), .st_valid(st_valid), .st_sop(st_sop),
    .st_eop(st_eop), .st_ready(st_ready), .pix_valid(pix_valid), .pix_data(pix_data), .pix_x(pix_x),
    .pix_line(pix_line), .pix_lower_plane(pix_lower_plane));
  vsp_src_model i_src (.hclk(hclk), .st_ready(st_ready), .st_data(st_data), .st_valid(st_valid),
    .st_sop(st_sop), .st_eop(st_eop));

  always @(posedge hclk) begin
    if (pix_valid === 1'b1) pq.push_back({pix_x, pix_line, pix_lower_plane, pix_data});
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    check(d & m, exp);
  endtask : reg_is

  task automatic send_ctrl(input logic [15:0] w, input logic [15:0] h, input logic [3:0] il);
    logic [35:0] n;
    n = {w, h, il};
    i_src.send(24'h3c5a0f, 1'b1, 1'b0, 0);
    for (int k = 0; k < 3; k++) begin
      i_src.send({4'ha, n[27-12*k -: 4], 4'h5, n[31-12*k -: 4], 4'hc, n[35-12*k -: 4]}, 1'b0, k == 2, k);
    end
    i_src.idle(3);
  endtask : send_ctrl

  task automatic reset_values();
    check({31'h0, st_ready}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    reg_is(REG_CTRL, 32'h1);
    reg_is(REG_WIDTH, 32'h0);
    reg_is(REG_HEIGHT, 32'h0);
    reg_is(REG_ILACE, 32'h1c3);
    reg_is(REG_FRAMES, 32'h0);
    reg_is(8'h40, 32'h0);
  endtask : reset_values

  task automatic ilace_codes();
    logic [3:0] c;
    foreach (ilace_list[i]) begin
      c = ilace_list[i];
      send_ctrl(16'h7e5d, {12'h2c1, c}, c);
      reg_is(REG_WIDTH, 32'h7e5d);
      reg_is(REG_HEIGHT, {16'h0, 12'h2c1, c});
      reg_is(REG_ILACE, {23'h0, c[3] ? c[1:0] != 2'b11 : c[1:0] != 2'b10, c[1:0], c[3] & c[2], c[3], c});
    end
  endtask : ilace_codes

  task automatic video_case(input int w, input int h, input logic [3:0] il);
    logic [56:0] e;
    logic [15:0] ln;
    send_ctrl(16'(w), 16'(h), il);
    reg_is(REG_STATUS, 32'h1f, 32'h1f);
    i_src.send(24'h0, 1'b1, 1'b0, 0);
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        i_src.send({8'(y), 8'(x), 8'ha5}, 1'b0, (y == h - 1) && (x == w - 1), x % 2);
      end
    end
    i_src.idle(3);
    frames++;
    check(32'(pq.size()), 32'(w * h));
    for (int i = 0; i < w * h; i++) begin
      e = pq.pop_front();
      ln = il[3] ? 16'(2 * (i / w) + il[2]) : 16'(i / w);
      check({16'h0, e[56:41]}, 32'(i % w));
      check({16'h0, e[40:25]}, {16'h0, ln});
      check({31'h0, e[24]}, {31'h0, ln[0]});
      check({8'h0, e[23:0]}, {8'h0, 8'(i / w), 8'(i % w), 8'ha5});
    end
    reg_is(REG_FRAMES, 32'(frames));
    reg_is(REG_STATUS, 32'h0, 32'hf30);
  endtask : video_case

  // A video packet with no fresh control that ends early, then a control packet cut after one beat.
  task automatic bad_video();
    logic [56:0] e;
    i_src.send(24'h0, 1'b1, 1'b0, 0);
    i_src.send(24'h0000a5, 1'b0, 1'b1, 0);
    i_src.idle(3);
    i_src.send(24'h00000f, 1'b1, 1'b0, 0);
    i_src.send(24'h000000, 1'b0, 1'b1, 0);
    i_src.idle(3);
    frames++;
    check(32'(pq.size()), 32'h1);
    e = pq.pop_front();
    check({16'h0, e[40:25]}, 32'h1);
    reg_is(REG_ILACE, 32'h3c, 32'h3f);
    reg_is(REG_STATUS, 32'h70f, 32'hf3f);
    ahb(1'b1, REG_STATUS, 32'h700, junk);
    reg_is(REG_STATUS, 32'h0, 32'hf00);
    reg_is(REG_FRAMES, 32'(frames));
  endtask : bad_video

  task automatic other_types();
    logic rsvd;
    foreach (type_list[i]) begin
      i_src.send({20'h0, type_list[i]}, 1'b1, 1'b0, 0);
      i_src.send(24'h123456, 1'b0, 1'b1, 1);
      i_src.idle(2);
      rsvd = type_list[i] inside {[4'h9:4'hc], 4'he};
      reg_is(REG_STATUS, {20'h0, rsvd, 7'h0, type_list[i]}, 32'h80f);
      ahb(1'b1, REG_STATUS, 32'h800, junk);
      reg_is(REG_STATUS, 32'h0, 32'h800);
    end
  endtask : other_types

  task automatic disable_link();
    ahb(1'b1, REG_CTRL, 32'h0, junk);
    fork
      i_src.send(24'h00000d, 1'b1, 1'b1, 0);
    join_none
    @(posedge hclk);
    check({31'h0, st_ready}, 32'h0);
    reg_is(REG_CTRL, 32'h0);
    reg_is(REG_STATUS, 32'hc, 32'h2f);
    ahb(1'b1, REG_CTRL, 32'h1, junk);
    @(posedge hclk);
    check({31'h0, st_ready}, 32'h1);
    wait fork;
    i_src.idle(2);
    reg_is(REG_STATUS, 32'hd, 32'h2f);
  endtask : disable_link

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_values();
    ilace_codes();
    video_case(3, 2, 4'b0011);
    video_case(2, 2, 4'b1100);
    video_case(4, 1, 4'b1000);
    bad_video();
    other_types();
    disable_link();
    print_verdict();
  end
endmodule : tb_vsp_sink
